// file: icu_pkg.sv
package icu_pkg;
	localparam int unsigned CLOCK_HZ = 20_000_000;
	localparam int unsigned QUARTERS_PER_CYCLE = 4;

	localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_EN_GROUP0 = 8'h04;
	localparam logic [7:0] ADDR_EN_GROUP1 = 8'h08;
	localparam logic [7:0] ADDR_EN_GROUP2 = 8'h0C;
	localparam logic [7:0] ADDR_FLAG_GROUP0 = 8'h10;
	localparam logic [7:0] ADDR_FLAG_GROUP1 = 8'h14;
	localparam logic [7:0] ADDR_FLAG_GROUP2 = 8'h18;
	localparam logic [7:0] ADDR_PIN_SELECT = 8'h1C;
	localparam logic [7:0] ADDR_SH_WORK = 8'h20;
	localparam logic [7:0] ADDR_SH_STATUS = 8'h24;
	localparam logic [7:0] ADDR_SH_BANK = 8'h28;
	localparam logic [7:0] ADDR_SH_FSEL0 = 8'h2C;
	localparam logic [7:0] ADDR_SH_FSEL1 = 8'h30;
	localparam logic [7:0] ADDR_SH_PCHIGH = 8'h34;

	localparam int GLOBAL_BIT = 7;
	localparam int PERIPH_BIT = 6;
	localparam int EDGE_BIT = 0;
	localparam int EXT_BIT = 0;
	localparam int PINCHG_BIT = 4;
	localparam int TIMER0_BIT = 5;
	localparam int OSCFAIL_BIT = 7;
	localparam int CLKSW_BIT = 6;
	localparam int CONVTH_BIT = 1;
	localparam int CONVDONE_BIT = 0;
	localparam int ZEROX_BIT = 6;
	localparam int CMPB_BIT = 1;
	localparam int CMPA_BIT = 0;

	localparam logic [7:0] EN0_MASK = 8'h31;
	localparam logic [7:0] EN1_MASK = 8'hC3;
	localparam logic [7:0] EN2_MASK = 8'h43;
	localparam logic EDGE_RESET = 1'b1;
	localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
	localparam logic [15:0] VECTOR_ADDR = 16'h0004;
	localparam logic [4:0] SHADOW_BANK = 5'h1F;
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q4 = 2'h3;
	localparam int PIN_SEL_W = 5;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_AFTER_WAKE, SEQ_FLUSH, SEQ_PUSH} seq_e;

	typedef struct packed {
		logic [7:0] work;
		logic [7:0] status;
		logic [7:0] bank;
		logic [15:0] fsel0;
		logic [15:0] fsel1;
		logic [7:0] pc_high;
	} ctx_s;

	typedef struct packed {
		logic timer0;
		logic pin_change;
		logic osc_fail;
		logic clock_switch;
		logic conv_threshold;
		logic conv_done;
		logic zero_cross;
		logic comp_b;
		logic comp_a;
	} periph_event_s;

	typedef struct packed {
		logic global_irq_enable;
		logic periph_group_enable;
		logic ext_edge_select;
		logic [7:0] en0;
		logic [7:0] en1;
		logic [7:0] en2;
		logic [7:0] flag0;
		logic [7:0] flag1;
		logic [7:0] flag2;
		logic [PIN_SEL_W-1:0] pin_sel;
		logic [7:0] snap0;
		logic [7:0] snap1;
		logic [7:0] snap2;
		logic snap_periph;
		ctx_s shadow;
		ctx_s ctx_out;
		seq_e seq;
		logic [1:0] qph;
		logic sync1;
		logic sync2;
		logic pin_prev;
		logic edge_pend;
		logic irq_pend;
		logic sleep_prev;
		logic wake;
		logic flush;
		logic push;
		logic vector_go;
		logic [15:0] vaddr;
		logic restore;
		logic waitreq;
		logic [31:0] rdata;
	} state_s;
endpackage : icu_pkg

// file: interrupt_control_unit.sv
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// (R1) Synchronous event reaches vector in 3-4 cycles
// (R2) Asynchronous event reaches vector in 3-5 cycles
// (R3) Latency independent of instruction length
// (R4) External flag sampled once per cycle, Q1
// (R5) External flag may set Q4 through Q1
// (R6) Wake needs enables set before sleep
// (R7) Wake vectors only with global enable set
// (R8) Instruction after sleep runs before vectoring
// (R9) External pin edge triggered, enabled group0 bit0
// (R10) Edge select bit0: 1 rising, resets 1
// (R11) Valid edge sets flag; vector needs enables
// (R12) Entry saves context to shadows, except status bits 4 and 3
// (R13) Return restores shadows over service routine changes
// (R14) Shadow registers in bank 31, read/write
// (R15) Global enable bit7 gates all, resets 0
// (R16) Group-0 sources ignore peripheral group enable
// (R17) Flags set regardless of enables
// (R18) Group0 enables at bits 5,4,0
// (R19) Group1 enables at bits 7,6,1,0
// (R20) Group2 enables at bits 6,1,0
// (R21) Pin select register chooses external pin
// (R22) Entry: flush, clear enable and save, push, vector
// (R23) Return restores context and sets global enable
// (R24) Reset leaves all interrupts disabled
// (R25) Request is OR of gated flag-enable pairs
module interrupt_control_unit #(
	parameter int unsigned PIN_COUNT = 32
) (
	input wire logic clock,
	input wire logic clock_en,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [PIN_COUNT-1:0] gpio_pins,
	input wire icu_pkg::periph_event_s periph_events,
	input wire logic sleep_mode,
	input wire logic return_from_interrupt,
	input wire icu_pkg::ctx_s core_ctx,
	output logic [1:0] q_phase,
	output logic irq_request,
	output logic flush_prefetch,
	output logic push_pc,
	output logic vector_go,
	output logic [15:0] vector_addr,
	output icu_pkg::ctx_s restore_ctx,
	output logic restore_strobe,
	output logic wake,
	output logic global_irq_enable
);

	icu_pkg::state_s s_q;
	icu_pkg::state_s s_d;

	function automatic logic [31:0] read_reg(input icu_pkg::state_s s, input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		case (a)
			icu_pkg::ADDR_INTERRUPT_CONTROL: begin
				r[icu_pkg::GLOBAL_BIT] = s.global_irq_enable;
				r[icu_pkg::PERIPH_BIT] = s.periph_group_enable;
				r[icu_pkg::EDGE_BIT] = s.ext_edge_select;
			end
			icu_pkg::ADDR_EN_GROUP0: r[7:0] = s.en0;
			icu_pkg::ADDR_EN_GROUP1: r[7:0] = s.en1;
			icu_pkg::ADDR_EN_GROUP2: r[7:0] = s.en2;
			icu_pkg::ADDR_FLAG_GROUP0: r[7:0] = s.flag0;
			icu_pkg::ADDR_FLAG_GROUP1: r[7:0] = s.flag1;
			icu_pkg::ADDR_FLAG_GROUP2: r[7:0] = s.flag2;
			icu_pkg::ADDR_PIN_SELECT: r[icu_pkg::PIN_SEL_W-1:0] = s.pin_sel;
			icu_pkg::ADDR_SH_WORK: r[7:0] = s.shadow.work;
			icu_pkg::ADDR_SH_STATUS: r[7:0] = s.shadow.status;
			icu_pkg::ADDR_SH_BANK: r[7:0] = s.shadow.bank;
			icu_pkg::ADDR_SH_FSEL0: r[15:0] = s.shadow.fsel0;
			icu_pkg::ADDR_SH_FSEL1: r[15:0] = s.shadow.fsel1;
			icu_pkg::ADDR_SH_PCHIGH: r[7:0] = s.shadow.pc_high;
			default: r = '0;
		endcase
		return r;
	endfunction : read_reg

	function automatic logic any_pending(input logic [7:0] f, input logic [7:0] e);
		return |(f & e);
	endfunction : any_pending

	logic sel_pin;
	logic rise;
	logic fall;
	logic hit;
	logic window;
	logic wr_hit;
	logic enter;
	logic req;
	logic wake_cond;
	logic [7:0] set0;
	logic [7:0] set1;
	logic [7:0] set2;
	logic [7:0] clr0;
	logic [7:0] clr1;
	logic [7:0] clr2;

	// A pin select change can glitch the mux; the synchroniser absorbs it
	always_comb begin
		sel_pin = 1'b0;
		if (32'(s_q.pin_sel) < PIN_COUNT) begin
			sel_pin = gpio_pins[s_q.pin_sel]; // [R21]
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.flush = 1'b0;
		s_d.push = 1'b0;
		s_d.vector_go = 1'b0;
		s_d.restore = 1'b0;
		s_d.qph = s_q.qph + 2'h1;

		// The pin is asynchronous: two flops before any edge logic
		s_d.sync1 = sel_pin;
		s_d.sync2 = s_q.sync1;
		s_d.pin_prev = s_q.sync2;
		rise = s_q.sync2 & ~s_q.pin_prev;
		fall = ~s_q.sync2 & s_q.pin_prev;
		hit = s_q.ext_edge_select ? rise : fall; // [R9] [R10]

		// Edges seen in Q2/Q3 wait for the Q4-Q1 window
		window = (s_q.qph == icu_pkg::PH_Q4) || (s_q.qph == icu_pkg::PH_Q1);
		s_d.edge_pend = (s_q.edge_pend | hit) & ~window; // [R5] [R2]

		set0 = '0;
		set0[icu_pkg::EXT_BIT] = window & (s_q.edge_pend | hit); // [R11] [R5]
		set0[icu_pkg::TIMER0_BIT] = periph_events.timer0;
		set0[icu_pkg::PINCHG_BIT] = periph_events.pin_change;
		set1 = '0;
		set1[icu_pkg::OSCFAIL_BIT] = periph_events.osc_fail;
		set1[icu_pkg::CLKSW_BIT] = periph_events.clock_switch;
		set1[icu_pkg::CONVTH_BIT] = periph_events.conv_threshold;
		set1[icu_pkg::CONVDONE_BIT] = periph_events.conv_done;
		set2 = '0;
		set2[icu_pkg::ZEROX_BIT] = periph_events.zero_cross;
		set2[icu_pkg::CMPB_BIT] = periph_events.comp_b;
		set2[icu_pkg::CMPA_BIT] = periph_events.comp_a;

		wr_hit = avs_write & ~s_q.waitreq;
		clr0 = '0;
		clr1 = '0;
		clr2 = '0;
		if (wr_hit && avs_address == icu_pkg::ADDR_FLAG_GROUP0) begin
			clr0 = avs_writedata[7:0];
		end
		if (wr_hit && avs_address == icu_pkg::ADDR_FLAG_GROUP1) begin
			clr1 = avs_writedata[7:0];
		end
		if (wr_hit && avs_address == icu_pkg::ADDR_FLAG_GROUP2) begin
			clr2 = avs_writedata[7:0];
		end
		// Flags ignore every enable; a set in the clearing cycle wins
		s_d.flag0 = (s_q.flag0 & ~clr0) | set0; // [R17]
		s_d.flag1 = (s_q.flag1 & ~clr1) | set1; // [R17]
		s_d.flag2 = (s_q.flag2 & ~clr2) | set2; // [R17]

		if (wr_hit) begin
			case (avs_address)
				icu_pkg::ADDR_INTERRUPT_CONTROL: begin
					s_d.global_irq_enable = avs_writedata[icu_pkg::GLOBAL_BIT]; // [R15]
					s_d.periph_group_enable = avs_writedata[icu_pkg::PERIPH_BIT];
					s_d.ext_edge_select = avs_writedata[icu_pkg::EDGE_BIT]; // [R10]
				end
				icu_pkg::ADDR_EN_GROUP0: s_d.en0 = avs_writedata[7:0] & icu_pkg::EN0_MASK; // [R18]
				icu_pkg::ADDR_EN_GROUP1: s_d.en1 = avs_writedata[7:0] & icu_pkg::EN1_MASK; // [R19]
				icu_pkg::ADDR_EN_GROUP2: s_d.en2 = avs_writedata[7:0] & icu_pkg::EN2_MASK; // [R20]
				icu_pkg::ADDR_PIN_SELECT: s_d.pin_sel = avs_writedata[icu_pkg::PIN_SEL_W-1:0]; // [R21]
				icu_pkg::ADDR_SH_WORK: s_d.shadow.work = avs_writedata[7:0]; // [R14]
				icu_pkg::ADDR_SH_STATUS: s_d.shadow.status = avs_writedata[7:0] & icu_pkg::STATUS_SAVE_MASK;
				icu_pkg::ADDR_SH_BANK: s_d.shadow.bank = avs_writedata[7:0];
				icu_pkg::ADDR_SH_FSEL0: s_d.shadow.fsel0 = avs_writedata[15:0];
				icu_pkg::ADDR_SH_FSEL1: s_d.shadow.fsel1 = avs_writedata[15:0];
				icu_pkg::ADDR_SH_PCHIGH: s_d.shadow.pc_high = avs_writedata[7:0]; // [R14]
				default: ;
			endcase
		end

		// Group 0 needs only the global enable; groups 1-2 also the group enable
		req = s_q.global_irq_enable & (any_pending(s_q.flag0, s_q.en0) | (s_q.periph_group_enable
			& (any_pending(s_q.flag1, s_q.en1) | any_pending(s_q.flag2, s_q.en2)))); // [R25] [R16] [R15] [R11]
		s_d.irq_pend = req;

		// Enables are frozen at sleep entry; later writes cannot arm a wake
		if (sleep_mode && !s_q.sleep_prev) begin
			s_d.snap0 = s_q.en0; // [R6]
			s_d.snap1 = s_q.en1;
			s_d.snap2 = s_q.en2;
			s_d.snap_periph = s_q.periph_group_enable;
		end
		s_d.sleep_prev = sleep_mode;
		wake_cond = any_pending(s_q.flag0, s_q.snap0) | (s_q.snap_periph
			& (any_pending(s_q.flag1, s_q.snap1) | any_pending(s_q.flag2, s_q.snap2)));
		s_d.wake = sleep_mode & s_q.sleep_prev & wake_cond; // [R6]

		// Steps only on instruction-cycle boundaries, never on instruction length
		enter = 1'b0;
		if (s_q.qph == icu_pkg::PH_Q1) begin // [R4] [R3]
			case (s_q.seq)
				icu_pkg::SEQ_IDLE: begin
					if (sleep_mode) begin
						if (s_q.wake && s_q.global_irq_enable) begin
							s_d.seq = icu_pkg::SEQ_AFTER_WAKE; // [R7]
						end
					end else if (s_q.irq_pend && s_q.global_irq_enable) begin
						// The request is a cycle old; a fresh clear of the global enable must still block entry
						enter = 1'b1; // [R1] [R15]
					end
				end
				icu_pkg::SEQ_AFTER_WAKE: enter = 1'b1; // [R8]
				icu_pkg::SEQ_FLUSH: begin
					s_d.seq = icu_pkg::SEQ_PUSH;
					s_d.push = 1'b1; // [R22]
				end
				icu_pkg::SEQ_PUSH: begin
					s_d.seq = icu_pkg::SEQ_IDLE;
					s_d.vector_go = 1'b1; // [R22] [R1]
					s_d.vaddr = icu_pkg::VECTOR_ADDR;
				end
				default: s_d.seq = icu_pkg::SEQ_IDLE;
			endcase
		end

		// Hardware updates of the global enable override a same-cycle bus write
		if (enter) begin
			s_d.seq = icu_pkg::SEQ_FLUSH;
			s_d.flush = 1'b1; // [R22]
			s_d.global_irq_enable = 1'b0; // [R22]
			s_d.shadow = core_ctx; // [R12]
			s_d.shadow.status = core_ctx.status & icu_pkg::STATUS_SAVE_MASK; // [R12]
		end else if (return_from_interrupt) begin
			s_d.restore = 1'b1; // [R13] [R23]
			s_d.ctx_out = s_q.shadow;
			s_d.global_irq_enable = 1'b1; // [R23]
		end

		if (s_q.waitreq) begin
			if (avs_read || avs_write) begin
				s_d.waitreq = 1'b0;
				s_d.rdata = read_reg(s_q, avs_address);
			end
		end else begin
			s_d.waitreq = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0; // [R24]
			s_q.ext_edge_select <= icu_pkg::EDGE_RESET; // [R10]
			s_q.waitreq <= 1'b1;
		end else if (clock_en) begin
			s_q <= s_d;
		end
	end

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	assign q_phase = s_q.qph;
	assign irq_request = s_q.irq_pend;
	assign flush_prefetch = s_q.flush;
	assign push_pc = s_q.push;
	assign vector_go = s_q.vector_go;
	assign vector_addr = s_q.vaddr;
	assign restore_ctx = s_q.ctx_out;
	assign restore_strobe = s_q.restore;
	assign wake = s_q.wake;
	assign global_irq_enable = s_q.global_irq_enable;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_flush_on_q1: assert property ($rose(s_q.flush) |-> $past(s_q.qph) == icu_pkg::PH_Q1) // [R4]
		else $error("flush not started at Q1");

	a_entry_clears_enable: assert property ($rose(s_q.flush) |-> !s_q.global_irq_enable && $past(s_q.global_irq_enable)
		|| $past(s_q.seq) == icu_pkg::SEQ_AFTER_WAKE) // [R22]
		else $error("entry did not clear global enable");

	a_vector_after_push: assert property ($rose(s_q.vector_go) |->
		$past(s_q.seq) == icu_pkg::SEQ_PUSH && s_q.vaddr == icu_pkg::VECTOR_ADDR) // [R1]
		else $error("vector without push step");

	a_push_after_flush: assert property ($rose(s_q.push) |-> $past(s_q.seq) == icu_pkg::SEQ_FLUSH) // [R22]
		else $error("push without flush step");

	a_ext_flag_window: assert property ($rose(s_q.flag0[icu_pkg::EXT_BIT]) |->
		$past(s_q.qph) == icu_pkg::PH_Q4 || $past(s_q.qph) == icu_pkg::PH_Q1) // [R5]
		else $error("external flag set outside window");

	a_group0_no_periph: assert property ($rose(s_q.irq_pend) && !$past(s_q.periph_group_enable) |->
		$past(|(s_q.flag0 & s_q.en0))) // [R16]
		else $error("peripheral request passed without group enable");

	a_request_needs_global: assert property ($rose(s_q.irq_pend) |-> $past(s_q.global_irq_enable)) // [R15]
		else $error("request raised while globally disabled");

	a_return_sets_enable: assert property ($rose(s_q.restore) |-> s_q.global_irq_enable
		&& (s_q.ctx_out.status & ~icu_pkg::STATUS_SAVE_MASK) == 8'h00) // [R23]
		else $error("return did not set global enable");

	a_status_masked: assert property ((s_q.shadow.status & ~icu_pkg::STATUS_SAVE_MASK) == 8'h00) // [R12]
		else $error("shadow status holds excluded bits");

	a_wake_then_step: assert property ($rose(s_q.seq == icu_pkg::SEQ_AFTER_WAKE) |->
		$past(s_q.global_irq_enable) && $past(s_q.wake)) // [R7]
		else $error("post-sleep step without global enable");

	a_enable_masks: assert property ((s_q.en0 & ~icu_pkg::EN0_MASK) == 8'h00
		&& (s_q.en1 & ~icu_pkg::EN1_MASK) == 8'h00 && (s_q.en2 & ~icu_pkg::EN2_MASK) == 8'h00) // [R18]
		else $error("unimplemented enable bit set");

	a_bus_answer: assert property ((avs_read || avs_write) && s_q.waitreq && clock_en |=> !s_q.waitreq)
		else $error("bus request not answered in one cycle");

	// Flags must follow their events whatever the enables say
	a_timer_flag_sets: assert property (periph_events.timer0 && clock_en |=> s_q.flag0[icu_pkg::TIMER0_BIT]) // [R17]
		else $error("timer flag missed its event");

	a_pinchg_flag_sets: assert property (periph_events.pin_change && clock_en |=> s_q.flag0[icu_pkg::PINCHG_BIT]) // [R17]
		else $error("pin change flag missed its event");

	a_convdone_flag_sets: assert property (periph_events.conv_done && clock_en |=> s_q.flag1[icu_pkg::CONVDONE_BIT]) // [R17]
		else $error("converter flag missed its event");

	a_zerox_flag_sets: assert property (periph_events.zero_cross && clock_en |=> s_q.flag2[icu_pkg::ZEROX_BIT]) // [R17]
		else $error("zero cross flag missed its event");

	a_restore_copies_shadow: assert property ($rose(s_q.restore) |-> s_q.ctx_out == $past(s_q.shadow)) // [R13]
		else $error("restored context differs from shadow");

	a_entry_saves_work: assert property ($rose(s_q.flush) |-> s_q.shadow.work == $past(core_ctx.work)) // [R12]
		else $error("working register not saved on entry");

	a_wake_only_asleep: assert property (s_q.wake |-> $past(sleep_mode)) // [R6]
		else $error("wake raised while awake");

	a_request_held_global: assert property (s_q.irq_pend |-> $past(s_q.global_irq_enable)) // [R15]
		else $error("request held without global enable");

	// Quarter phase must never skip; entry timing relies on it
	a_phase_steps: assert property (clock_en |=> s_q.qph == $past(s_q.qph) + 2'h1) // [R4]
		else $error("quarter phase skipped");

	a_vector_addr_fixed: assert property (s_q.vector_go |-> s_q.vaddr == icu_pkg::VECTOR_ADDR) // [R22]
		else $error("vector address wrong");

endmodule : interrupt_control_unit

// file: core_model.sv
`timescale 1ns/1ps
// Stand-in for the core: leaves the service routine a fixed time after vectoring
module core_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic vector_go,
	input wire logic restore_strobe,
	input wire icu_pkg::ctx_s restore_ctx,
	input wire logic wake,
	input wire icu_pkg::ctx_s ctx_load,
	input wire logic load_now,
	input wire logic sleep_req,
	output icu_pkg::ctx_s core_ctx,
	output logic return_from_interrupt,
	output logic sleep_mode
);
	logic [4:0] cnt_q;
	logic busy_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core_ctx <= '0;
			return_from_interrupt <= 1'b0;
			busy_q <= 1'b0;
			cnt_q <= 5'h0;
			sleep_mode <= 1'b0;
		end else begin
			return_from_interrupt <= 1'b0;
			if (load_now) begin
				core_ctx <= ctx_load;
			end else if (restore_strobe) begin
				core_ctx <= restore_ctx;
			end else if (vector_go) begin
				// The routine scribbles on W so a missing restore shows up
				core_ctx.work <= ~core_ctx.work;
			end
			if (vector_go) begin
				busy_q <= 1'b1;
				cnt_q <= 5'h18;
			end else if (busy_q) begin
				if (cnt_q == 5'h0) begin
					busy_q <= 1'b0;
					return_from_interrupt <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 5'h1;
				end
			end
			if (wake) begin
				sleep_mode <= 1'b0;
			end else if (sleep_req) begin
				sleep_mode <= 1'b1;
			end
		end
	end
endmodule : core_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
	logic clock, rst_n, avs_read, avs_write, avs_waitrequest, sleep_mode, return_from_interrupt, load_now;
	logic irq_request, flush_prefetch, push_pc, vector_go, restore_strobe, wake, global_irq_enable, sleep_req;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rnd, gpio_pins;
	logic [1:0] q_phase;
	logic [15:0] vector_addr;
	logic [95:0] big;
	logic [7:0] masks [3];
	icu_pkg::periph_event_s periph_events, ev;
	icu_pkg::ctx_s core_ctx, restore_ctx, ctx_load, exp_ctx;
	logic [31:0] rd_q [$];
	icu_pkg::ctx_s ctx_q [$];
	int mismatches, check_count, cycles, seed, n, p;

	interrupt_control_unit dut (.clock(clock), .clock_en(1'b1), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .gpio_pins(gpio_pins), .periph_events(periph_events),
		.sleep_mode(sleep_mode), .return_from_interrupt(return_from_interrupt), .core_ctx(core_ctx),
		.q_phase(q_phase), .irq_request(irq_request), .flush_prefetch(flush_prefetch), .push_pc(push_pc),
		.vector_go(vector_go), .vector_addr(vector_addr), .restore_ctx(restore_ctx),
		.restore_strobe(restore_strobe), .wake(wake), .global_irq_enable(global_irq_enable));
	core_model partner (.clock(clock), .rst_n(rst_n), .vector_go(vector_go), .restore_strobe(restore_strobe),
		.restore_ctx(restore_ctx), .wake(wake), .ctx_load(ctx_load), .load_now(load_now), .sleep_req(sleep_req),
		.core_ctx(core_ctx), .return_from_interrupt(return_from_interrupt), .sleep_mode(sleep_mode));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic cmp(input string what, input logic [71:0] exp, input logic [71:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	// Request is held until the edge at which waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(negedge clock); while (avs_waitrequest !== 1'b0);
		@(posedge clock);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, e);
	endtask : rd

	task automatic pulse(input icu_pkg::periph_event_s e);
		@(posedge clock);
		periph_events <= e;
		@(posedge clock);
		periph_events <= '0;
	endtask : pulse

	task automatic wait_vec(output int k);
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (vector_go !== 1'b1 && k < 40);
	endtask : wait_vec

	always @(negedge clock) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			cmp("readdata", rd_q.pop_front(), avs_readdata);
		if (flush_prefetch === 1'b1) begin
			cmp("flush phase", 2'h1, q_phase);
			cmp("global at flush", 0, global_irq_enable);
		end
		if (push_pc === 1'b1)
			cmp("push phase", 2'h1, q_phase);
		if (restore_strobe === 1'b1) begin
			cmp("restore_ctx", ctx_q.pop_front(), restore_ctx);
			cmp("global_irq_enable", 1, global_irq_enable);
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		seed = 16606;
		rst_n = 1'b0;
		{avs_read, avs_write, load_now, sleep_req} = 4'h0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		gpio_pins = 32'h0;
		periph_events = '0;
		ctx_load = '0;
		masks = '{icu_pkg::EN0_MASK, icu_pkg::EN1_MASK, icu_pkg::EN2_MASK};
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		rd(icu_pkg::ADDR_INTERRUPT_CONTROL, 32'h01);
		for (n = 0; n < 3; n++) begin
			rnd = $random(seed);
			rd(8'(icu_pkg::ADDR_EN_GROUP0 + 4 * n), 32'h0);
			bus(1'b1, 8'(icu_pkg::ADDR_EN_GROUP0 + 4 * n), rnd);
			rd(8'(icu_pkg::ADDR_EN_GROUP0 + 4 * n), {24'h0, rnd[7:0] & masks[n]});
			bus(1'b1, 8'(icu_pkg::ADDR_EN_GROUP0 + 4 * n), 32'h0);
		end
		bus(1'b1, 8'h3C, 32'hFF);
		rd(8'h3C, 32'h0);
		bus(1'b1, icu_pkg::ADDR_INTERRUPT_CONTROL, 32'hFF);
		rd(icu_pkg::ADDR_INTERRUPT_CONTROL, 32'hC1);
		bus(1'b1, icu_pkg::ADDR_INTERRUPT_CONTROL, 32'h01);
		rnd = $random(seed);
		bus(1'b1, icu_pkg::ADDR_SH_STATUS, rnd);
		rd(icu_pkg::ADDR_SH_STATUS, {24'h0, rnd[7:0] & icu_pkg::STATUS_SAVE_MASK});
		ev = '0;
		ev.timer0 = 1'b1;
		pulse(ev);
		repeat (4) @(negedge clock);
		cmp("irq_request", 0, irq_request);
		rd(icu_pkg::ADDR_FLAG_GROUP0, 32'h20);
		bus(1'b1, icu_pkg::ADDR_FLAG_GROUP0, 32'h20);
		// External pin on a random pin choice, the neighbour must not count
		p = $unsigned($random(seed)) % 32;
		bus(1'b1, icu_pkg::ADDR_PIN_SELECT, p);
		gpio_pins[p ^ 1] <= 1'b1;
		repeat (12) @(posedge clock);
		gpio_pins[p ^ 1] <= 1'b0;
		repeat (12) @(posedge clock);
		rd(icu_pkg::ADDR_FLAG_GROUP0, 32'h0);
		gpio_pins[p] <= 1'b1;
		repeat (12) @(posedge clock);
		rd(icu_pkg::ADDR_FLAG_GROUP0, 32'h01);
		bus(1'b1, icu_pkg::ADDR_FLAG_GROUP0, 32'h01);
		bus(1'b1, icu_pkg::ADDR_INTERRUPT_CONTROL, 32'h00);
		gpio_pins[p] <= 1'b0;
		repeat (12) @(posedge clock);
		rd(icu_pkg::ADDR_FLAG_GROUP0, 32'h01);
		bus(1'b1, icu_pkg::ADDR_FLAG_GROUP0, 32'h01);
		// Group 0 entry without the peripheral group enable
		big = {$random(seed), $random(seed), $random(seed)};
		exp_ctx = big[71:0];
		@(posedge clock);
		ctx_load <= exp_ctx;
		load_now <= 1'b1;
		@(posedge clock);
		load_now <= 1'b0;
		bus(1'b1, icu_pkg::ADDR_EN_GROUP0, 32'h20);
		bus(1'b1, icu_pkg::ADDR_INTERRUPT_CONTROL, 32'h81);
		pulse(ev);
		wait_vec(n);
		cmp("latency in range", 1, n >= 9 && n <= 17);
		cmp("vector_addr", icu_pkg::VECTOR_ADDR, vector_addr);
		cmp("global_irq_enable", 0, global_irq_enable);
		exp_ctx.status = exp_ctx.status & icu_pkg::STATUS_SAVE_MASK;
		rd(icu_pkg::ADDR_SH_WORK, {24'h0, exp_ctx.work});
		rd(icu_pkg::ADDR_SH_STATUS, {24'h0, exp_ctx.status});
		rnd = $random(seed);
		bus(1'b1, icu_pkg::ADDR_SH_WORK, rnd);
		exp_ctx.work = rnd[7:0];
		ctx_q.push_back(exp_ctx);
		bus(1'b1, icu_pkg::ADDR_FLAG_GROUP0, 32'h20);
		repeat (30) @(posedge clock);
		rd(icu_pkg::ADDR_INTERRUPT_CONTROL, 32'h81);
		// Group 1 source waits for the peripheral group enable
		bus(1'b1, icu_pkg::ADDR_EN_GROUP1, 32'h01);
		ev = '0;
		ev.conv_done = 1'b1;
		pulse(ev);
		repeat (12) @(negedge clock);
		cmp("irq_request", 0, irq_request);
		rd(icu_pkg::ADDR_FLAG_GROUP1, 32'h01);
		bus(1'b1, icu_pkg::ADDR_INTERRUPT_CONTROL, 32'h41);
		repeat (4) @(negedge clock);
		cmp("irq_request", 0, irq_request);
		ctx_q.push_back(exp_ctx);
		bus(1'b1, icu_pkg::ADDR_INTERRUPT_CONTROL, 32'hC1);
		wait_vec(n);
		cmp("vectored", 1, n < 40);
		bus(1'b1, icu_pkg::ADDR_FLAG_GROUP1, 32'h01);
		repeat (30) @(posedge clock);
		// Sleep with global enable off: wake only, no vectoring
		bus(1'b1, icu_pkg::ADDR_INTERRUPT_CONTROL, 32'h41);
		@(posedge clock);
		sleep_req <= 1'b1;
		@(posedge clock);
		sleep_req <= 1'b0;
		repeat (3) @(posedge clock);
		ev = '0;
		ev.timer0 = 1'b1;
		pulse(ev);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (wake !== 1'b1 && n < 20);
		cmp("wake seen", 1, n < 20);
		wait_vec(n);
		cmp("cycles without vector", 40, n);
		bus(1'b1, icu_pkg::ADDR_FLAG_GROUP0, 32'h20);
		// Sleep with global enable on: wake must lead to the vector
		bus(1'b1, icu_pkg::ADDR_INTERRUPT_CONTROL, 32'hC1);
		ctx_q.push_back(exp_ctx);
		@(posedge clock);
		sleep_req <= 1'b1;
		@(posedge clock);
		sleep_req <= 1'b0;
		repeat (3) @(posedge clock);
		pulse(ev);
		wait_vec(n);
		cmp("vectored after wake", 1, n < 40);
		bus(1'b1, icu_pkg::ADDR_FLAG_GROUP0, 32'h20);
		repeat (30) @(posedge clock);
		cmp("returns seen", 0, ctx_q.size());
		give_verdict();
	end
endmodule : tb
